// >>> logic/utr_result_regs.sv
/*
 upstream tof result register bank: wave ratios and first/second hit times.
 assumes the measurement engine presents results with a one-cycle done pulse on core_clk,
 and the serial port decoder presents a read address and a write strobe on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module utr_result_regs #(
	parameter int RATIO_W = utr_pkg::RATIO_W,
	parameter int INT_W   = utr_pkg::INT_W,
	parameter int DATA_W  = utr_pkg::DATA_W,
	parameter int ADDR_W  = utr_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// results from the measurement engine
	input  wire logic               meas_done,
	input  wire logic [RATIO_W-1:0] wave_ratio_first_second,
	input  wire logic [RATIO_W-1:0] wave_ratio_second_ideal,
	input  wire logic [INT_W-1:0]   first_hit_whole_periods_in,
	input  wire logic [DATA_W-1:0]  first_hit_sub_period_in,
	input  wire logic [INT_W-1:0]   second_hit_whole_periods_in,
	input  wire logic [DATA_W-1:0]  second_hit_sub_period_in,
	// register port
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic               reg_wr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	output logic      [DATA_W-1:0]  reg_rdata,
	output logic                    reg_hit
);
	// ==========================================================
	// result storage
	logic [DATA_W-1:0] wave_ratio_upstream_r, wave_ratio_upstream_nxt;
	logic [INT_W-1:0]  first_hit_whole_periods_r, first_hit_whole_periods_nxt;
	logic [DATA_W-1:0] first_hit_sub_period_r, first_hit_sub_period_nxt;
	logic [INT_W-1:0]  second_hit_whole_periods_r, second_hit_whole_periods_nxt;
	logic [DATA_W-1:0] second_hit_sub_period_r, second_hit_sub_period_nxt;
	logic [DATA_W-1:0] reg_rdata_nxt;
	logic              reg_hit_nxt;

	// ==========================================================
	// width guard and helpers
	// ratio bytes pack into one word and counts are padded, so the widths must fit that word
	if (2 * RATIO_W != DATA_W || INT_W >= DATA_W || ADDR_W < $bits(utr_pkg::OFS_WAVE_RATIO)) begin
		$error("utr_result_regs: width parameters do not fit the register word");
	end

	// integer registers read their unused top bits as zero
	function automatic logic [DATA_W-1:0] pad_int(input logic [INT_W-1:0] count);
		return DATA_W'(count);
	endfunction

	// the five result addresses; everything else reads as unmapped
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		return (addr == utr_pkg::OFS_WAVE_RATIO) || (addr == utr_pkg::OFS_HIT1_INT)
			|| (addr == utr_pkg::OFS_HIT1_FRAC) || (addr == utr_pkg::OFS_HIT2_INT)
			|| (addr == utr_pkg::OFS_HIT2_FRAC);
	endfunction

	// write data is deliberately unused: nothing here is host-writable
	always_comb begin
		wave_ratio_upstream_nxt      = wave_ratio_upstream_r;
		first_hit_whole_periods_nxt  = first_hit_whole_periods_r;
		first_hit_sub_period_nxt     = first_hit_sub_period_r;
		second_hit_whole_periods_nxt = second_hit_whole_periods_r;
		second_hit_sub_period_nxt    = second_hit_sub_period_r;
		if (meas_done) begin
			wave_ratio_upstream_nxt      = {wave_ratio_first_second, wave_ratio_second_ideal};
			first_hit_whole_periods_nxt  = first_hit_whole_periods_in;
			first_hit_sub_period_nxt     = first_hit_sub_period_in;
			second_hit_whole_periods_nxt = second_hit_whole_periods_in;
			second_hit_sub_period_nxt    = second_hit_sub_period_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wave_ratio_upstream_r      <= DATA_W'(utr_pkg::RESULT_RESET);
			first_hit_whole_periods_r  <= INT_W'(utr_pkg::RESULT_RESET);
			first_hit_sub_period_r     <= DATA_W'(utr_pkg::RESULT_RESET);
			second_hit_whole_periods_r <= INT_W'(utr_pkg::RESULT_RESET);
			second_hit_sub_period_r    <= DATA_W'(utr_pkg::RESULT_RESET);
		end else begin
			wave_ratio_upstream_r      <= wave_ratio_upstream_nxt;
			first_hit_whole_periods_r  <= first_hit_whole_periods_nxt;
			first_hit_sub_period_r     <= first_hit_sub_period_nxt;
			second_hit_whole_periods_r <= second_hit_whole_periods_nxt;
			second_hit_sub_period_r    <= second_hit_sub_period_nxt;
		end
	end

	// ==========================================================
	// read decode, registered; integer registers read their top bit as zero
	// unmapped reads answer zero with the hit flag low, so a hole is told apart from a zero result
	always_comb begin
		reg_hit_nxt = 1'b1;
		unique case (reg_addr)
			utr_pkg::OFS_WAVE_RATIO: reg_rdata_nxt = wave_ratio_upstream_r;
			utr_pkg::OFS_HIT1_INT:   reg_rdata_nxt = pad_int(first_hit_whole_periods_r);
			utr_pkg::OFS_HIT1_FRAC:  reg_rdata_nxt = first_hit_sub_period_r;
			utr_pkg::OFS_HIT2_INT:   reg_rdata_nxt = pad_int(second_hit_whole_periods_r);
			utr_pkg::OFS_HIT2_FRAC:  reg_rdata_nxt = second_hit_sub_period_r;
			default: begin
				reg_rdata_nxt = DATA_W'(utr_pkg::UNMAPPED_READ);
				reg_hit_nxt   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= DATA_W'(utr_pkg::RESULT_RESET);
			reg_hit   <= 1'b0;
		end else begin
			reg_rdata <= reg_rdata_nxt;
			reg_hit   <= reg_hit_nxt;
		end
	end

	// ==========================================================
	// checks
	// results land one edge after the completion pulse; reads answer one edge after the address
	property p_write_ignored;
		@(posedge core_clk) disable iff (rst)
		(reg_wr && !meas_done) |=> $stable(wave_ratio_upstream_r)
			&& $stable(first_hit_whole_periods_r) && $stable(first_hit_sub_period_r)
			&& $stable(second_hit_whole_periods_r) && $stable(second_hit_sub_period_r);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("host write changed a result");

	property p_reset_clear;
		@(posedge core_clk) rst |=> wave_ratio_upstream_r == DATA_W'(utr_pkg::RESULT_RESET)
			&& first_hit_whole_periods_r == INT_W'(utr_pkg::RESULT_RESET)
			&& first_hit_sub_period_r == DATA_W'(utr_pkg::RESULT_RESET)
			&& second_hit_whole_periods_r == INT_W'(utr_pkg::RESULT_RESET)
			&& second_hit_sub_period_r == DATA_W'(utr_pkg::RESULT_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("result not cleared by reset");

	property p_reset_read;
		@(posedge core_clk) rst |=> reg_rdata == DATA_W'(utr_pkg::RESULT_RESET) && !reg_hit;
	endproperty
	a_reset_read: assert property (p_reset_read) else $error("read port not cleared by reset");

	property p_ratio_pack;
		@(posedge core_clk) disable iff (rst)
		meas_done |=> wave_ratio_upstream_r == {$past(wave_ratio_first_second), $past(wave_ratio_second_ideal)};
	endproperty
	a_ratio_pack: assert property (p_ratio_pack) else $error("wave ratio bytes misplaced");

	property p_ratio_read;
		@(posedge core_clk) disable iff (rst)
		(reg_addr == utr_pkg::OFS_WAVE_RATIO) |=> reg_rdata == $past(wave_ratio_upstream_r) && reg_hit;
	endproperty
	a_ratio_read: assert property (p_ratio_read) else $error("wave ratio read wrong");

	property p_hit1_load;
		@(posedge core_clk) disable iff (rst)
		meas_done |=> first_hit_whole_periods_r == $past(first_hit_whole_periods_in);
	endproperty
	a_hit1_load: assert property (p_hit1_load) else $error("first hit integer not captured");

	property p_hit1_int_read;
		@(posedge core_clk) disable iff (rst)
		(reg_addr == utr_pkg::OFS_HIT1_INT) |=> reg_rdata[DATA_W-1:INT_W] == '0
			&& reg_rdata[INT_W-1:0] == $past(first_hit_whole_periods_r) && reg_hit;
	endproperty
	a_hit1_int_read: assert property (p_hit1_int_read) else $error("first hit integer read wrong");

	property p_hit1_frac;
		@(posedge core_clk) disable iff (rst)
		meas_done ##1 (reg_addr == utr_pkg::OFS_HIT1_FRAC) |=> reg_rdata == $past(first_hit_sub_period_in, 2);
	endproperty
	a_hit1_frac: assert property (p_hit1_frac) else $error("first hit fraction read wrong");

	property p_hit1_frac_load;
		@(posedge core_clk) disable iff (rst)
		meas_done |=> first_hit_sub_period_r == $past(first_hit_sub_period_in);
	endproperty
	a_hit1_frac_load: assert property (p_hit1_frac_load) else $error("first hit fraction not captured");

	property p_hit1_frac_read;
		@(posedge core_clk) disable iff (rst)
		(reg_addr == utr_pkg::OFS_HIT1_FRAC) |=> reg_rdata == $past(first_hit_sub_period_r) && reg_hit;
	endproperty
	a_hit1_frac_read: assert property (p_hit1_frac_read) else $error("first hit fraction port wrong");

	property p_hit2;
		@(posedge core_clk) disable iff (rst)
		meas_done |=> second_hit_whole_periods_r == $past(second_hit_whole_periods_in)
			&& second_hit_sub_period_r == $past(second_hit_sub_period_in);
	endproperty
	a_hit2: assert property (p_hit2) else $error("second hit not captured");

	property p_hit2_int_read;
		@(posedge core_clk) disable iff (rst)
		(reg_addr == utr_pkg::OFS_HIT2_INT) |=> reg_rdata[DATA_W-1:INT_W] == '0
			&& reg_rdata[INT_W-1:0] == $past(second_hit_whole_periods_r) && reg_hit;
	endproperty
	a_hit2_int_read: assert property (p_hit2_int_read) else $error("second hit integer read wrong");

	property p_hit2_frac_read;
		@(posedge core_clk) disable iff (rst)
		(reg_addr == utr_pkg::OFS_HIT2_FRAC) |=> reg_rdata == $past(second_hit_sub_period_r) && reg_hit;
	endproperty
	a_hit2_frac_read: assert property (p_hit2_frac_read) else $error("second hit fraction read wrong");

	property p_hold;
		@(posedge core_clk) disable iff (rst)
		!meas_done |=> $stable(wave_ratio_upstream_r)
			&& $stable(first_hit_whole_periods_r) && $stable(first_hit_sub_period_r)
			&& $stable(second_hit_whole_periods_r) && $stable(second_hit_sub_period_r);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without completion");

	property p_unmapped;
		@(posedge core_clk) disable iff (rst)
		!addr_mapped(reg_addr) |=> !reg_hit && reg_rdata == DATA_W'(utr_pkg::UNMAPPED_READ);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address answered");
endmodule
`default_nettype wire

// >>> common/utr_pkg.sv
/*
 upstream time-of-flight result register constants: offsets, widths, reset value.
 assumes one 16-bit register word per address on the register port.
*/
// Summary of operation
// - result registers are read-only and volatile; host writes are ignored
// - power-on reset clears every result register to zero
// - wave ratio: upper byte t1/t2, lower byte t2/ideal, 1.7 unsigned fixed point
// - ideal width is half the configured upstream launch period, computed by engine
// - first hit whole periods: 15-bit count of 4 MHz periods, max 7FFFh
// - first hit sub period: 16-bit fraction of one 4 MHz period
// - second hit uses integer then fraction registers in same formats
package utr_pkg;
	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 16;
	localparam int          INT_W             = 15;
	localparam int          RATIO_W           = 8;
	localparam logic [7:0]  OFS_WAVE_RATIO    = 8'hc4;
	localparam logic [7:0]  OFS_HIT1_INT      = 8'hc5;
	localparam logic [7:0]  OFS_HIT1_FRAC     = 8'hc6;
	localparam logic [7:0]  OFS_HIT2_INT      = 8'hc7;
	localparam logic [7:0]  OFS_HIT2_FRAC     = 8'hc8;
	localparam logic [15:0] RESULT_RESET      = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ     = 16'h0000;
endpackage

// >>> testbench/utr_result_regs_tb.sv
/*
 bench for the upstream result bank: loads results, reads them back, tries writes and resets.
 assumes a one-cycle registered read port and a one-cycle load pulse from the engine.
*/
`timescale 1ns/100ps
`default_nettype none
module utr_result_regs_tb;
	// ==========================================
	// stimulus and observation
	logic        core_clk = 0, rst = 1, meas_done = 0, reg_wr = 0, reg_hit;
	logic [7:0]  r_hi = 0, r_lo = 0, reg_addr = 0;
	logic [14:0] i1 = 0, i2 = 0;
	logic [15:0] f1 = 0, f2 = 0, reg_wdata = 0, reg_rdata;
	logic [15:0] exp_v [5];
	int          fail_count = 0, checks_done = 0;
	always #5 core_clk = ~core_clk;
	utr_result_regs utr_result_regs_i (.core_clk(core_clk), .rst(rst), .meas_done(meas_done),
		.wave_ratio_first_second(r_hi), .wave_ratio_second_ideal(r_lo),
		.first_hit_whole_periods_in(i1), .first_hit_sub_period_in(f1),
		.second_hit_whole_periods_in(i2), .second_hit_sub_period_in(f2),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
	// ==========================================
	// shared tasks
	task rd(input logic [7:0] a, input logic [15:0] e, input logic h);
		@(posedge core_clk);
		#1 reg_addr = a;
		@(posedge core_clk);
		#1 checks_done++;
		if (reg_rdata !== e || reg_hit !== h) begin
			fail_count++;
			$display("ERROR %0t addr %h got %h/%b want %h/%b", $time, a, reg_rdata, reg_hit, e, h);
		end
	endtask
	// mapped addresses run c4..c8 in the order of exp_v
	task rd_all;
		for (int k = 0; k < 5; k++)
			rd(8'hc4 + 8'(k), exp_v[k], 1'b1);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task t_reset;
		exp_v = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		rd_all;
		rd(8'hc3, 16'h0000, 1'b0);
		rd(8'hc9, 16'h0000, 1'b0);
		$display("reset values done");
	endtask
	// boundary values; a read in the load cycle still sees the old value; inputs then change without a pulse
	task t_load;
		@(posedge core_clk);
		#1 {r_hi, r_lo, i1, f1, i2, f2, meas_done} = {8'hfe, 8'h01, 15'h7fff, 16'hffff, 15'h0001, 16'h8000, 1'b1};
		reg_addr = 8'hc6;
		@(posedge core_clk);
		#1 {r_hi, r_lo, i1, f1, i2, f2, meas_done} = {8'h11, 8'h22, 15'h0333, 16'h4444, 15'h0555, 16'h6666, 1'b0};
		checks_done++;
		if (reg_rdata !== 16'h0000 || reg_hit !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t read in the load cycle got %h/%b, want old value 0000/1", $time, reg_rdata, reg_hit);
		end
		exp_v = '{16'hfe01, 16'h7fff, 16'hffff, 16'h0001, 16'h8000};
		rd_all;
		$display("load and hold done");
	endtask
	// host writes to every result address must leave the values alone
	task t_write;
		for (int k = 0; k < 5; k++) begin
			@(posedge core_clk);
			#1 {reg_addr, reg_wr, reg_wdata} = {8'hc4 + 8'(k), 1'b1, 16'ha5a5};
		end
		@(posedge core_clk);
		#1 reg_wr = 0;
		rd_all;
		$display("write ignore done");
	endtask
	task t_rereset;
		@(posedge core_clk);
		#1 rst = 1;
		@(posedge core_clk);
		#1 rst = 0;
		exp_v = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		rd_all;
		$display("mid-run reset done");
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 rst = 0;
		t_reset;
		t_load;
		t_write;
		t_rereset;
		close_out;
	end
endmodule
`default_nettype wire
